// file: rtl/sfrb_map.svh
`ifndef SFRB_MAP_SVH
`define SFRB_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define SFRB_IDX_IND_PORT  9'h180
`define SFRB_IDX_TMR_OPT   9'h181
`define SFRB_IDX_PC_LO     9'h182
`define SFRB_IDX_STATUS    9'h183
`define SFRB_IDX_IND_PTR   9'h184
`define SFRB_IDX_PORT_DIR  9'h186
`define SFRB_IDX_PC_HI     9'h18a
`define SFRB_IDX_INT_CTRL  9'h18b
`define SFRB_BANK_BASE     9'h180
`define SFRB_BANK_END      9'h1a0
`define SFRB_ODD_BANK_BIT  7

// ----------------------------------------------------------------------
// bus address fields
// ----------------------------------------------------------------------
`define SFRB_APB_IDX_HI    10
`define SFRB_APB_IDX_LO    2
`define SFRB_APB_TOP_BIT   11

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define SFRB_ST_CARRY      0
`define SFRB_ST_DIGIT      1
`define SFRB_ST_ZERO       2
`define SFRB_ST_SLP        3
`define SFRB_ST_WDX        4
`define SFRB_ST_RP_LO      5
`define SFRB_ST_RP_HI      6
`define SFRB_ST_IRP        7

// ----------------------------------------------------------------------
// interrupt control flag positions
// ----------------------------------------------------------------------
`define SFRB_IC_CHG_FLAG   0
`define SFRB_IC_EXT_FLAG   1
`define SFRB_IC_TMR_FLAG   2

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define SFRB_RST_TMR_OPT   8'hff
`define SFRB_RST_PC_LO     8'h00
`define SFRB_RST_STATUS    8'h18
`define SFRB_RST_IND_PTR   8'h00
`define SFRB_RST_PORT_DIR  8'hff
`define SFRB_RST_PC_HI     5'h00
`define SFRB_RST_INT_CTRL  8'h00
`define SFRB_PC_HI_W       5

`endif

// file: rtl/sfrb_pkg.sv
package sfrb_pkg;

  // instruction classes presented on the execute port
  typedef enum logic [3:0] {
    op_move_w      = 4'h0,
    op_clear_reg   = 4'h1,
    op_bit_clear   = 4'h2,
    op_bit_set     = 4'h3,
    op_nibble_swap = 4'h4,
    op_add_reg     = 4'h5,
    op_sub_reg     = 4'h6,
    op_add_lit     = 4'h7,
    op_sub_lit     = 4'h8,
    op_inc_reg     = 4'h9,
    op_and_reg     = 4'ha
  } sfrb_op_t;

  // physical register selected by a data-space address
  typedef enum logic [3:0] {
    sel_none      = 4'h0,
    sel_ind_port  = 4'h1,
    sel_tmr_opt   = 4'h2,
    sel_pc_lo     = 4'h3,
    sel_status    = 4'h4,
    sel_ind_ptr   = 4'h5,
    sel_port_dir  = 4'h6,
    sel_pc_hi     = 4'h7,
    sel_int_ctrl  = 4'h8
  } sfrb_sel_t;

endpackage

// file: rtl/sfrb_alu.sv
`timescale 1ns/1ps
`include "sfrb_map.svh"

module sfrb_alu (
  input  sfrb_pkg::sfrb_op_t op,
  input  wire logic [7:0]    opnd_a,
  input  wire logic [7:0]    opnd_w,
  input  wire logic [2:0]    bit_sel,
  output logic      [7:0]    result,
  output logic               zero,
  output logic               digit_carry,
  output logic               carry,
  output logic               aff_zero,
  output logic               aff_carries
);
  import sfrb_pkg::*;

  logic       is_sub;
  logic [7:0] addend;
  logic [8:0] sum;
  logic [4:0] nib;

  // subtraction adds the two's complement, so carries become inverted borrows
  assign is_sub = (op == op_sub_reg) || (op == op_sub_lit);
  assign addend = (op == op_inc_reg) ? 8'h01 : (is_sub ? ~opnd_w : opnd_w);
  assign sum    = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, is_sub};
  assign nib    = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};

  // result and flag-affect selection
  always_comb begin
    result      = 8'h00;
    aff_zero    = 1'b0;
    aff_carries = 1'b0;
    case (op)
      op_move_w:      result = opnd_w;
      op_clear_reg: begin
        result   = 8'h00;
        aff_zero = 1'b1;
      end
      op_bit_clear:   result = opnd_a & ~(8'h01 << bit_sel);
      op_bit_set:     result = opnd_a | (8'h01 << bit_sel);
      op_nibble_swap: result = {opnd_a[3:0], opnd_a[7:4]};
      op_add_reg, op_sub_reg, op_add_lit, op_sub_lit: begin
        result      = sum[7:0];
        aff_zero    = 1'b1;
        aff_carries = 1'b1;
      end
      op_inc_reg: begin
        result   = sum[7:0];
        aff_zero = 1'b1;
      end
      op_and_reg: begin
        result   = opnd_a & opnd_w;
        aff_zero = 1'b1;
      end
      default:        result = 8'h00;
    endcase
  end

  // carry out of bit 3 and of the top bit
  assign zero        = (result == 8'h00);
  assign digit_carry = nib[4];
  assign carry       = sum[8];

endmodule

// file: rtl/sfrb_bank.sv
`timescale 1ns/1ps
`include "sfrb_map.svh"

// Summary of operation
// - status holds ALU flags, reset-cause flags and bank select bits.
// - status may be the destination of any register-form instruction like any register.
// - flag-updating instruction into status drops written flags, uses ALU flags.
// - instruction writes to watchdog expiry and sleep entry flags are ignored.
// - clear into status zeroes upper three bits, sets zero, keeps rest.
// - in subtraction carry and digit carry are inverted borrows.
// - unimplemented locations in the bank read as zero.
// - direct bank from two bank bits; indirect bank bit picks bank pair.
// - expiry flag cleared on watchdog timeout, set on power-up, clear, sleep.
// - sleep entry flag cleared by sleep, set on power-up or watchdog clear.
// - digit carry from bit 3 carry, carry from top bit carry.
module sfrb_bank (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic      [31:0]   prdata,
  output logic               pslverr,
  input  wire logic          ex_valid,
  input  sfrb_pkg::sfrb_op_t ex_op,
  input  wire logic [8:0]    ex_addr,
  input  wire logic          ex_dest_f,
  input  wire logic [7:0]    ex_w,
  input  wire logic [7:0]    ex_lit,
  input  wire logic [2:0]    ex_bit,
  output logic      [7:0]    ex_result,
  output logic               ex_done,
  input  wire logic          wdt_timeout,
  input  wire logic          clrwdt_exec,
  input  wire logic          sleep_exec,
  input  wire logic          tmr0_overflow,
  input  wire logic          ext_int_event,
  input  wire logic          portb_change,
  output logic      [1:0]    direct_bank,
  output logic               indirect_bank_bit,
  output logic      [7:0]    option_cfg,
  output logic      [7:0]    port_dir,
  output logic      [7:0]    pc_low,
  output logic      [4:0]    pc_high,
  output logic      [7:0]    intr_ctrl,
  output logic      [7:0]    status_out
);
  import sfrb_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]               tmr_opt_q;
  logic [7:0]               pc_lo_q;
  logic [7:0]               status_q;
  logic [7:0]               status_d;
  logic [7:0]               ind_ptr_q;
  logic [7:0]               port_dir_q;
  logic [`SFRB_PC_HI_W-1:0] pc_hi_q;
  logic [7:0]               int_ctrl_q;
  logic [7:0]               ex_result_q;
  logic                     ex_done_q;
  logic [31:0]              prdata_q;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // mirrored registers map every bank alias onto one select
  function automatic sfrb_sel_t decode(input logic [8:0] a);
    sfrb_sel_t s;
    s = sel_none;
    if (a[6:0] == 7'(`SFRB_IDX_IND_PORT)) begin
      s = sel_ind_port;
    end else if (a[6:0] == 7'(`SFRB_IDX_PC_LO)) begin
      s = sel_pc_lo;
    end else if (a[6:0] == 7'(`SFRB_IDX_STATUS)) begin
      s = sel_status;
    end else if (a[6:0] == 7'(`SFRB_IDX_IND_PTR)) begin
      s = sel_ind_ptr;
    end else if (a[6:0] == 7'(`SFRB_IDX_PC_HI)) begin
      s = sel_pc_hi;
    end else if (a[6:0] == 7'(`SFRB_IDX_INT_CTRL)) begin
      s = sel_int_ctrl;
    end else if (a[`SFRB_ODD_BANK_BIT] && a[6:0] == 7'(`SFRB_IDX_TMR_OPT)) begin
      s = sel_tmr_opt;
    end else if (a[`SFRB_ODD_BANK_BIT] && a[6:0] == 7'(`SFRB_IDX_PORT_DIR)) begin
      s = sel_port_dir;
    end
    return s;
  endfunction

  logic [8:0] ind_addr;
  sfrb_sel_t  ind_sel;
  logic [8:0] apb_idx;
  logic       apb_bad;
  sfrb_sel_t  apb_sel;
  sfrb_sel_t  apb_tgt;
  sfrb_sel_t  ex_sel;
  sfrb_sel_t  ex_tgt;

  // indirect pointer extended by the indirect bank bit
  assign ind_addr = {status_q[`SFRB_ST_IRP], ind_ptr_q};
  assign ind_sel  = decode(ind_addr);
  assign apb_idx  = paddr[`SFRB_APB_IDX_HI:`SFRB_APB_IDX_LO];
  assign apb_bad  = paddr[`SFRB_APB_TOP_BIT] || (paddr[1:0] != 2'h0) ||
                    (apb_idx < `SFRB_BANK_BASE) || (apb_idx >= `SFRB_BANK_END);
  assign apb_sel  = apb_bad ? sel_none : decode(apb_idx);
  assign ex_sel   = decode(ex_addr);

  // the indirect port resolves through the pointer; pointing at itself is void
  assign apb_tgt = (apb_sel != sel_ind_port) ? apb_sel :
                   ((ind_sel == sel_ind_port) ? sel_none : ind_sel);
  assign ex_tgt  = (ex_sel != sel_ind_port) ? ex_sel :
                   ((ind_sel == sel_ind_port) ? sel_none : ind_sel);

  // read value of a physical register, zero where nothing is implemented
  function automatic logic [7:0] read_sel(input sfrb_sel_t s);
    logic [7:0] v;
    v = 8'h00;
    case (s)
      sel_tmr_opt:  v = tmr_opt_q;
      sel_pc_lo:    v = pc_lo_q;
      sel_status:   v = status_q;
      sel_ind_ptr:  v = ind_ptr_q;
      sel_port_dir: v = port_dir_q;
      sel_pc_hi:    v = {3'h0, pc_hi_q};
      sel_int_ctrl: v = int_ctrl_q;
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // instruction execution
  // ----------------------------------------------------------------------
  logic       lit_op;
  logic       ex_wr_f;
  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic       alu_z;
  logic       alu_dc;
  logic       alu_c;
  logic       aff_z;
  logic       aff_cdc;

  assign lit_op  = (ex_op == op_add_lit) || (ex_op == op_sub_lit);
  assign alu_a   = lit_op ? ex_lit : read_sel(ex_tgt);
  // status is an ordinary destination for any register-form instruction
  assign ex_wr_f = ex_valid && !lit_op &&
                   (ex_dest_f || ex_op == op_move_w || ex_op == op_clear_reg ||
                    ex_op == op_bit_clear || ex_op == op_bit_set);

  sfrb_alu u_alu (
    .op          (ex_op),
    .opnd_a      (alu_a),
    .opnd_w      (ex_w),
    .bit_sel     (ex_bit),
    .result      (alu_res),
    .zero        (alu_z),
    .digit_carry (alu_dc),
    .carry       (alu_c),
    .aff_zero    (aff_z),
    .aff_carries (aff_cdc)
  );

  // working-register result and completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_result_q <= 8'h00;
      ex_done_q   <= 1'b0;
    end else begin
      ex_done_q <= ex_valid;
      if (ex_valid && !ex_wr_f) begin
        ex_result_q <= alu_res;
      end
    end
  end

  // ----------------------------------------------------------------------
  // shared write port: instruction first, bus waits
  // ----------------------------------------------------------------------
  logic       apb_wr;
  sfrb_sel_t  wr_sel;
  logic [7:0] wr_data;

  assign pready = !ex_valid;
  assign apb_wr = psel && penable && pwrite && pready && !apb_bad;

  always_comb begin
    wr_sel  = sel_none;
    wr_data = 8'h00;
    if (ex_wr_f) begin
      wr_sel  = ex_tgt;
      wr_data = alu_res;
    end else if (apb_wr) begin
      wr_sel  = apb_tgt;
      wr_data = pwdata[7:0];
    end
  end

  // plain read/write registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_opt_q  <= `SFRB_RST_TMR_OPT;
      pc_lo_q    <= `SFRB_RST_PC_LO;
      ind_ptr_q  <= `SFRB_RST_IND_PTR;
      port_dir_q <= `SFRB_RST_PORT_DIR;
      pc_hi_q    <= `SFRB_RST_PC_HI;
    end else begin
      if (wr_sel == sel_tmr_opt)  tmr_opt_q  <= wr_data;
      if (wr_sel == sel_pc_lo)    pc_lo_q    <= wr_data;
      if (wr_sel == sel_ind_ptr)  ind_ptr_q  <= wr_data;
      if (wr_sel == sel_port_dir) port_dir_q <= wr_data;
      if (wr_sel == sel_pc_hi)    pc_hi_q    <= wr_data[`SFRB_PC_HI_W-1:0];
    end
  end

  // interrupt control: hardware flag sets win over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ctrl_q <= `SFRB_RST_INT_CTRL;
    end else begin
      int_ctrl_q <= (wr_sel == sel_int_ctrl) ? wr_data : int_ctrl_q;
      if (tmr0_overflow) int_ctrl_q[`SFRB_IC_TMR_FLAG] <= 1'b1;
      if (ext_int_event) int_ctrl_q[`SFRB_IC_EXT_FLAG] <= 1'b1;
      if (portb_change)  int_ctrl_q[`SFRB_IC_CHG_FLAG] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------------
  logic flag_guard;

  // a flag-updating instruction never writes the three flags directly
  assign flag_guard = ex_valid && (aff_z || aff_cdc);

  always_comb begin
    status_d = status_q;
    if (wr_sel == sel_status) begin
      status_d[`SFRB_ST_IRP:`SFRB_ST_RP_LO] = wr_data[`SFRB_ST_IRP:`SFRB_ST_RP_LO];
      if (!flag_guard) begin
        status_d[`SFRB_ST_ZERO:`SFRB_ST_CARRY] = wr_data[`SFRB_ST_ZERO:`SFRB_ST_CARRY];
      end
    end
    if (ex_valid && aff_z) begin
      status_d[`SFRB_ST_ZERO] = alu_z;
    end
    if (ex_valid && aff_cdc) begin
      status_d[`SFRB_ST_CARRY] = alu_c;
      status_d[`SFRB_ST_DIGIT] = alu_dc;
    end
    // reset-cause flags change only on hardware events
    if (clrwdt_exec) begin
      status_d[`SFRB_ST_WDX] = 1'b1;
      status_d[`SFRB_ST_SLP] = 1'b1;
    end
    if (sleep_exec) begin
      status_d[`SFRB_ST_WDX] = 1'b1;
      status_d[`SFRB_ST_SLP] = 1'b0;
    end
    if (wdt_timeout) begin
      status_d[`SFRB_ST_WDX] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `SFRB_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------------
  // bus read data and outputs
  // ----------------------------------------------------------------------
  // sampled while selected, so a stalled access returns fresh data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel) begin
      prdata_q <= {24'h00_0000, read_sel(apb_tgt)};
    end
  end

  assign prdata            = prdata_q;
  assign pslverr           = psel && penable && apb_bad;
  assign ex_result         = ex_result_q;
  assign ex_done           = ex_done_q;
  assign direct_bank       = status_q[`SFRB_ST_RP_HI:`SFRB_ST_RP_LO];
  assign indirect_bank_bit = status_q[`SFRB_ST_IRP];
  assign option_cfg        = tmr_opt_q;
  assign port_dir          = port_dir_q;
  assign pc_low            = pc_lo_q;
  assign pc_high           = pc_hi_q;
  assign intr_ctrl         = int_ctrl_q;
  assign status_out        = status_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic quiet_events;
  assign quiet_events = !wdt_timeout && !clrwdt_exec && !sleep_exec;

  a_expiry_timeout:
    assert property (wdt_timeout |=> !status_q[`SFRB_ST_WDX])
    else $error("expiry flag not cleared by timeout");

  a_sleep_entry:
    assert property (sleep_exec |=> !status_q[`SFRB_ST_SLP] ##0 status_q[`SFRB_ST_WDX]
                     || $past(wdt_timeout))
    else $error("sleep did not update reset-cause flags");

  a_cause_locked:
    assert property (quiet_events |=> $stable(status_q[`SFRB_ST_WDX:`SFRB_ST_SLP]))
    else $error("reset-cause flags changed without an event");

  a_clear_status:
    assert property (ex_valid && ex_op == op_clear_reg && ex_tgt == sel_status
                     |=> status_q[7:5] == 3'h0 && status_q[`SFRB_ST_ZERO] &&
                         status_q[1:0] == $past(status_q[1:0]))
    else $error("clear of status gave wrong value");

  a_flag_wins:
    assert property (ex_valid && aff_cdc && ex_tgt == sel_status && ex_wr_f
                     |=> status_q[`SFRB_ST_CARRY] == $past(alu_c) &&
                         status_q[`SFRB_ST_DIGIT] == $past(alu_dc))
    else $error("written flags not replaced by result flags");

  a_bank_select:
    assert property (apb_wr && apb_tgt == sel_status
                     |=> direct_bank == $past(pwdata[6:5]))
    else $error("bank select not taken from status write");

  a_unimpl_zero:
    assert property (psel && !penable && apb_tgt == sel_none |=> prdata == 32'h0)
    else $error("unimplemented location read nonzero");

  a_alias_shared:
    assert property (ex_valid && ex_op == op_move_w && ex_addr == 9'h004
                     |=> ind_ptr_q == $past(ex_w) ##1 prdata_q[7:0] == ind_ptr_q
                         || !$past(psel) || $past(apb_tgt) != sel_ind_ptr)
    else $error("mirrored pointer write not visible");

  a_sub_borrow:
    assert property (ex_valid && ex_op == op_sub_lit |-> alu_c == (ex_w <= ex_lit))
    else $error("carry is not inverted borrow");

  a_digit_carry:
    assert property (ex_valid && ex_op == op_add_lit
                     |-> alu_dc == ((5'(ex_w[3:0]) + 5'(ex_lit[3:0])) > 5'd15))
    else $error("digit carry wrong on add");

endmodule

// file: tb/sfrb_bank_bench.sv
`timescale 1ns/1ps

module sfrb_bank_bench;
  import sfrb_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        ex_valid, ex_dest_f, ex_done, indirect_bank_bit;
  sfrb_op_t    ex_op;
  logic [8:0]  ex_addr;
  logic [7:0]  ex_w, ex_lit, ex_result, option_cfg, port_dir, pc_low, intr_ctrl, status_out;
  logic [2:0]  ex_bit;
  logic [5:0]  ev_q;
  logic [1:0]  direct_bank;
  logic [4:0]  pc_high;
  int          num_errors, total_checks;

  sfrb_bank u_sfrb_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ex_valid(ex_valid), .ex_op(ex_op), .ex_addr(ex_addr), .ex_dest_f(ex_dest_f),
    .ex_w(ex_w), .ex_lit(ex_lit), .ex_bit(ex_bit), .ex_result(ex_result), .ex_done(ex_done),
    .wdt_timeout(ev_q[0]), .clrwdt_exec(ev_q[1]), .sleep_exec(ev_q[2]),
    .tmr0_overflow(ev_q[3]), .ext_int_event(ev_q[4]), .portb_change(ev_q[5]),
    .direct_bank(direct_bank), .indirect_bank_bit(indirect_bank_bit),
    .option_cfg(option_cfg), .port_dir(port_dir), .pc_low(pc_low), .pc_high(pc_high),
    .intr_ctrl(intr_ctrl), .status_out(status_out)
  );

  // ----------------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; index is the register index, byte address is four times it
  task automatic apb(logic wr, logic [8:0] idx, logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {1'b0, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the slave; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one executed instruction, checks the completion pulse
  task automatic exe(sfrb_op_t op, logic [8:0] a, logic f, logic [7:0] w, logic [2:0] b);
    @(posedge pclk);
    ex_valid  <= 1'b1;
    ex_op     <= op;
    ex_addr   <= a;
    ex_dest_f <= f;
    ex_w      <= w;
    ex_bit    <= b;
    @(posedge pclk);
    ex_valid  <= 1'b0;
    @(posedge pclk);
    chk("ex_done", ex_done, 1'b1);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_map();
    logic [8:0]  ix [10] = '{9'h181, 9'h182, 9'h183, 9'h184, 9'h186, 9'h18a, 9'h18b,
                             9'h185, 9'h19f, 9'h189};
    logic [7:0]  ex [10] = '{8'hff, 8'h00, 8'h18, 8'h00, 8'hff, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00};
    logic [31:0] rd;
    logic        er;
    foreach (ix[i]) begin
      apb(1'b0, ix[i], 8'h00, rd, er);
      chk("reset read", rd, {24'h0, ex[i]});
    end
    apb(1'b1, 9'h185, 8'h5a, rd, er);
    apb(1'b0, 9'h185, 8'h00, rd, er);
    chk("unimpl after write", rd, 32'h0);
    apb(1'b0, 9'h1a0, 8'h00, rd, er);
    chk("out of window err", er, 1'b1);
  endtask

  task automatic t_status_bus();
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 9'h183, 8'h00, rd, er);
    apb(1'b0, 9'h183, 8'h00, rd, er);
    chk("status cause flags kept", rd, 32'h18);
    apb(1'b1, 9'h183, 8'hff, rd, er);
    // the write lands at the edge the access ends; look one edge later
    @(posedge pclk);
    chk("status all set", status_out, 8'hff);
    chk("direct bank 11", direct_bank, 2'b11);
    chk("indirect bank", indirect_bank_bit, 1'b1);
  endtask

  task automatic t_status_exec();
    exe(op_clear_reg, 9'h003, 1'b1, 8'h00, 3'd0);
    chk("clear status", status_out, 8'h1f);
    exe(op_bit_set, 9'h103, 1'b1, 8'h00, 3'd5);
    chk("bank bit set", direct_bank, 2'b01);
    exe(op_bit_clear, 9'h183, 1'b1, 8'h00, 3'd5);
    chk("bank bit clear", status_out, 8'h1f);
    exe(op_move_w, 9'h083, 1'b1, 8'he4, 3'd0);
    chk("move into status", status_out, 8'hfc);
    exe(op_move_w, 9'h183, 1'b1, 8'h00, 3'd0);
    chk("move zero", status_out, 8'h18);
    exe(op_sub_reg, 9'h183, 1'b1, 8'h08, 3'd0);
    chk("sub into status", status_out, 8'h1b);
  endtask

  task automatic t_alu_flags();
    sfrb_op_t    op [4] = '{op_add_reg, op_add_reg, op_sub_reg, op_sub_reg};
    logic [7:0]  w  [4] = '{8'h08, 8'he8, 8'h08, 8'h19};
    logic [7:0]  rs [4] = '{8'h20, 8'h00, 8'h10, 8'hff};
    logic [7:0]  st [4] = '{8'h1a, 8'h1f, 8'h1b, 8'h18};
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 9'h184, 8'h18, rd, er);
    foreach (op[i]) begin
      exe(op[i], 9'h004, 1'b0, w[i], 3'd0);
      chk("alu result", ex_result, rs[i]);
      chk("alu flags", status_out, st[i]);
    end
  endtask

  task automatic t_events();
    logic [5:0] ev [6] = '{6'h04, 6'h02, 6'h01, 6'h08, 6'h10, 6'h20};
    logic [7:0] st [6] = '{8'h10, 8'h18, 8'h08, 8'h08, 8'h08, 8'h08};
    logic [7:0] ic [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h06, 8'h07};
    foreach (ev[i]) begin
      @(posedge pclk);
      ev_q <= ev[i];
      @(posedge pclk);
      ev_q <= 6'h00;
      @(posedge pclk);
      chk("cause flags", status_out, st[i]);
      chk("int flags", intr_ctrl, ic[i]);
    end
  endtask

  task automatic t_mirror();
    logic [31:0] rd;
    logic        er;
    exe(op_move_w, 9'h00a, 1'b1, 8'h15, 3'd0);
    apb(1'b0, 9'h18a, 8'h00, rd, er);
    chk("pc high alias", rd, 32'h15);
    chk("pc high port", pc_high, 5'h15);
    exe(op_move_w, 9'h004, 1'b1, 8'h8a, 3'd0);
    apb(1'b0, 9'h184, 8'h00, rd, er);
    chk("pointer alias", rd, 32'h8a);
    apb(1'b0, 9'h180, 8'h00, rd, er);
    chk("indirect read", rd, 32'h15);
    exe(op_move_w, 9'h081, 1'b1, 8'ha5, 3'd0);
    chk("option alias", option_cfg, 8'ha5);
    exe(op_move_w, 9'h001, 1'b1, 8'h00, 3'd0);
    chk("option not in bank 0", option_cfg, 8'ha5);
    exe(op_move_w, 9'h086, 1'b1, 8'h0f, 3'd0);
    chk("port dir alias", port_dir, 8'h0f);
    exe(op_move_w, 9'h102, 1'b1, 8'h77, 3'd0);
    apb(1'b0, 9'h182, 8'h00, rd, er);
    chk("pc low alias", rd, 32'h77);
    chk("pc low port", pc_low, 8'h77);
  endtask

  // literal forms: result to w, flags into status
  task automatic t_literal();
    ex_lit <= 8'h0f;
    exe(op_add_lit, 9'h000, 1'b0, 8'h01, 3'd0);
    chk("add literal", ex_result, 8'h10);
    chk("add literal flags", status_out, 8'h0a);
    ex_lit <= 8'h20;
    exe(op_sub_lit, 9'h000, 1'b0, 8'h20, 3'd0);
    chk("sub literal", ex_result, 8'h00);
    chk("sub literal flags", status_out, 8'h0f);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    num_errors   = 0;
    total_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, ex_valid, ex_dest_f} = '0;
    paddr = '0;
    pwdata = '0;
    ex_op = op_move_w;
    {ex_addr, ex_w, ex_lit, ex_bit, ev_q} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_status_bus();
    t_status_exec();
    t_alu_flags();
    t_events();
    t_mirror();
    t_literal();
    end_sim();
  end

endmodule
